// ==== carriage_pkg.sv ====
// Shared constants and types for the carriage space and restore control
package carriage_pkg;
  localparam int CLOCK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
  // Index degrees per millisecond, in tenths
  localparam int DEG_X10_PER_MS_100CPM = 6;
  localparam int DEG_X10_PER_MS_150CPM = 9;
  localparam int TENTHS = 10;
  localparam int CYC_PER_DEG_100CPM = CYCLES_PER_MS * TENTHS /
                                      DEG_X10_PER_MS_100CPM;
  localparam int CYC_PER_DEG_150CPM = CYCLES_PER_MS * TENTHS /
                                      DEG_X10_PER_MS_150CPM;
  localparam int PRE_W = 17;
  localparam int DEG_W = 9;
  localparam logic [DEG_W-1:0] DEG_LAST = 9'h167;
  localparam int LAT_W = 6;
  localparam logic [LAT_W-1:0] SPACE_START_DEG = 6'h0D;
  localparam logic [LAT_W-1:0] SKIP_START_DEG = 6'h14;
  localparam int LINE_W = 8;
  localparam int EST_W = 16;
  localparam logic [EST_W-1:0] SKIP_LINE_DEG_X10 = 16'h0072;
  localparam logic [EST_W-1:0] SKIP_FIRST_DEG_X10 = 16'h00C8;
  localparam logic [7:0] RPM_SLOW = 8'h3E;
  localparam logic [7:0] RPM_FAST = 8'h88;
  localparam int CANCEL_HOLD_MS = 1;
  localparam int HOLD_W = 16;
  // Cam contacts on the machine-cycle degree counter
  localparam int NUM_CAMS = 3;
  localparam int CAM_SPACE = 0;
  localparam int CAM_SKIP = 1;
  localparam int CAM_LOCK = 2;
  localparam logic [DEG_W-1:0] CAM_CLOSE_DEG [NUM_CAMS] =
    '{9'h000, 9'h109, 9'h000};
  localparam logic [DEG_W-1:0] CAM_OPEN_DEG [NUM_CAMS] =
    '{9'h00F, 9'h11D, 9'h0B4};
  // APB map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DEGREE = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_RPM = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_SKIP = 12'h010;
  localparam int CTRL_RATE150_BIT = 0;
  localparam int CTRL_PRINT_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  typedef struct packed {
    logic spaceKey;
    logic stopKey;
    logic restoreKey;
  } keys_s;

  typedef struct packed {
    logic motorEnable;
    logic slowClutch;
    logic fastClutch;
    logic interposerMagnet;
    logic clutchMagnet;
    logic cancelDelay;
    logic fastStopThird;
    logic fastStopSecond;
    logic fastStopFirst;
    logic restoreDone;
    logic spaceLockout;
    logic stopLatch;
    logic restoreLatch;
    logic startLatch;
  } status_s;
endpackage

// ==== degree_counter.sv ====
// Machine-cycle index degree counter with a per-degree tick
`timescale 1ns/1ps
module degree_counter
  import carriage_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [PRE_W-1:0] cyclesPerDegree,
  output logic [DEG_W-1:0] degree,
  output logic degTick,
  output logic cycleEnd
);
  logic [PRE_W-1:0] prescale;
  wire preDone = prescale >= (cyclesPerDegree - PRE_W'(1));
  wire degWrap = preDone && (degree == DEG_LAST);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= '0;
      degree <= '0;
      degTick <= 1'b0;
      cycleEnd <= 1'b0;
    end else begin
      prescale <= preDone ? '0 : prescale + PRE_W'(1);
      degTick <= preDone;
      cycleEnd <= degWrap;
      if (preDone) begin
        degree <= degWrap ? '0 : degree + DEG_W'(1);
      end
    end
  end
endmodule

// ==== cam_contact.sv ====
// One cam contact closed over a degree window, wrap-around allowed
`timescale 1ns/1ps
module cam_contact
  import carriage_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [DEG_W-1:0] degree,
  input wire logic [DEG_W-1:0] closeDeg,
  input wire logic [DEG_W-1:0] openDeg,
  output logic closed
);
  wire inOrder = closeDeg <= openDeg;
  wire afterClose = degree >= closeDeg;
  wire beforeOpen = degree < openDeg;
  wire inWindow = inOrder ? (afterClose && beforeOpen)
                          : (afterClose || beforeOpen);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      closed <= 1'b0;
    end else begin
      closed <= inWindow;
    end
  end
endmodule

// ==== carriage_space_restore_control.sv ====
// Relay-sequence control for the tape carriage: clutches, keys, restore
//
// Summary of operation
// - Motor runs only with host main line on and gang punch off.
// - Normal spacing, restore and overflow use the slow clutch, 62 rpm.
// - Every skip-to operation uses the fast clutch, 136 rpm.
// - Degrees per millisecond: 0.6 at 100 cpm, 0.9 at 150 cpm.
// - While printing, host space cam closing sets start latch, drives clutch.
// - Fast operation: interposer first, clutch only after interposer contact.
// - Start latency 13 degrees space, 20 skip, plus 11.4 per line.
// - Start latch feeds clutch directly, or via interposer when skipping.
// - Space key gives exactly one slow line space however long held.
// - Space key sets start latch and lockout; cam holds, key re-holds lockout.
// - Breaker sets fast stops; first drops clutch, second drops start latch.
// - Fast stops act well under one millisecond after breaker closes.
// - Stop key held clears host run, start and restore latches.
// - Carriage stop key halts the host at the end of current cycle.
// - Restore key advances slowly until channel 1 hole is sensed.
// - Restore: restore latch, start latch, done clears, clutch, then hold.
// - During restore stops wait for channel 1; then stops and delay hold.
// - Done latch releases stops; delay keeps pending skips cancelled.
// - Restore key still held: no new restore, stops block clutch.
// - Commutator turns 62 rpm on slow clutch, 136 rpm on fast.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module carriage_space_restore_control
  import carriage_pkg::*;
#(
  parameter int CYC_PER_DEG_100 = CYC_PER_DEG_100CPM,
  parameter int CYC_PER_DEG_150 = CYC_PER_DEG_150CPM,
  parameter int CANCEL_HOLD_CYCLES = CANCEL_HOLD_MS * CYCLES_PER_MS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mainLineOn,
  input wire logic gangPunchOff,
  input wire keys_s keys,
  input wire logic carriageBreaker,
  input wire logic channel1Brush,
  input wire logic skipSelect,
  input wire logic interposerContact,
  input wire logic hostStart,
  output logic motorEnable,
  output logic clutchMagnet,
  output logic interposerMagnet,
  output logic fastClutch,
  output logic slowClutch,
  output logic hostRunA,
  output logic hostRunB,
  output logic hostStop,
  output logic cancelPending
);
  // Relay latches
  logic startLatch;
  logic restoreLatch;
  logic stopLatch;
  logic spaceLockout;
  logic restoreDone;
  logic fastStopFirst;
  logic fastStopSecond;
  logic fastStopThird;
  logic cancelDelay;
  logic stopPending;
  logic [CTRL_W-1:0] ctrl;
  logic [NUM_CAMS-1:0] camPrev;
  logic [LAT_W-1:0] latency;
  logic [LINE_W-1:0] skipLines;
  logic [HOLD_W-1:0] cancelHold;
  logic breakerPrev;

  wire [DEG_W-1:0] degree;
  wire degTick;
  wire cycleEnd;
  wire [NUM_CAMS-1:0] camClosed;

  // Degree rate follows the host list speed
  wire rate150 = ctrl[CTRL_RATE150_BIT];
  wire printEnable = ctrl[CTRL_PRINT_BIT];
  wire [PRE_W-1:0] cyclesPerDegree = rate150 ? PRE_W'(CYC_PER_DEG_150)
                                             : PRE_W'(CYC_PER_DEG_100);

  degree_counter u_degree (
    .clock(clock),
    .rst_n(rst_n),
    .cyclesPerDegree(cyclesPerDegree),
    .degree(degree),
    .degTick(degTick),
    .cycleEnd(cycleEnd)
  );

  genvar i;
  generate
    for (i = 0; i < NUM_CAMS; i++) begin : g_cam
      cam_contact u_cam (
        .clock(clock),
        .rst_n(rst_n),
        .degree(degree),
        .closeDeg(CAM_CLOSE_DEG[i]),
        .openDeg(CAM_OPEN_DEG[i]),
        .closed(camClosed[i])
      );
    end
  endgenerate

  // Keys only reach the relays through the gang punch switch
  wire spaceKeyOn = keys.spaceKey & gangPunchOff;
  wire stopKeyOn = keys.stopKey & gangPunchOff;
  wire restoreKeyOn = keys.restoreKey & gangPunchOff;

  // Cam closures act as impulses so one closure gives one start
  wire [NUM_CAMS-1:0] camMake = camClosed & ~camPrev;
  wire hostSpacePick = printEnable & camMake[CAM_SPACE];
  wire skipPick = skipSelect & camMake[CAM_SKIP];
  wire spacePick = spaceKeyOn & ~spaceLockout;
  wire restorePick = restoreLatch & restoreKeyOn;
  wire startHold = startLatch & ~fastStopSecond;
  wire anyPick = hostSpacePick | skipPick | spacePick | restorePick;
  wire next_startLatch = (anyPick | startHold) & ~stopLatch;

  wire restoreHold = restoreLatch & startLatch;
  wire next_restoreLatch = (restoreKeyOn | restoreHold) & ~stopLatch;

  // Lockout keeps a held space key from repicking the start latch
  wire lockHold = camClosed[CAM_LOCK] | spaceKeyOn;
  wire next_spaceLockout = startLatch | (spaceLockout & lockHold);

  // Breaker ignored during restore until the channel 1 hole
  wire breakerStop = carriageBreaker & ~restoreLatch;
  wire restoreStop = carriageBreaker & restoreLatch & channel1Brush;
  wire delayHold = fastStopThird & ~restoreDone;
  wire keyHeldHold = fastStopFirst & restoreLatch & restoreKeyOn;
  wire next_fastStop = breakerStop | restoreStop | delayHold | keyHeldHold;
  wire next_fastStopThird = restoreStop | delayHold;

  // Start latency in index degrees since the start latch set
  wire spaceReady = latency >= SPACE_START_DEG;
  wire skipReady = latency >= SKIP_START_DEG;
  wire latencyRun = startLatch & degTick & ~skipReady;

  // Restore always runs slow, even with a skip selection standing
  wire fastPath = skipSelect & ~restoreLatch;
  wire clutchFeed = startLatch & ~fastStopFirst & spaceReady;
  wire next_interposer = clutchFeed & fastPath;
  wire sealed = interposerMagnet & interposerContact;
  wire fastFeed = clutchFeed & skipReady & sealed;
  wire next_clutch = fastPath ? fastFeed : clutchFeed;

  // Lines skipped under a held fast clutch
  wire breakerMake = carriageBreaker & ~breakerPrev;
  wire lineCount = breakerMake & fastClutch & (skipLines != '1);
  wire [EST_W-1:0] skipEstimate = SKIP_FIRST_DEG_X10 +
    EST_W'(skipLines) * SKIP_LINE_DEG_X10;

  wire [7:0] rpm = fastClutch ? RPM_FAST :
                   slowClutch ? RPM_SLOW : 8'h00;

  wire next_hostRunA = (hostStart | hostRunA) & ~stopLatch;
  wire next_hostRunB = (hostStart | hostRunB) & ~stopLatch;
  wire next_stopPending = stopLatch | (stopPending & ~cycleEnd);

  // Cancel stays asserted a while after the delay relay drops
  wire holdRun = cancelHold != '0;
  wire [HOLD_W-1:0] next_cancelHold = cancelDelay ?
    HOLD_W'(CANCEL_HOLD_CYCLES) : (holdRun ? cancelHold - HOLD_W'(1) : '0);

  status_s status;
  assign status = '{
    motorEnable: motorEnable,
    slowClutch: slowClutch,
    fastClutch: fastClutch,
    interposerMagnet: interposerMagnet,
    clutchMagnet: clutchMagnet,
    cancelDelay: cancelDelay,
    fastStopThird: fastStopThird,
    fastStopSecond: fastStopSecond,
    fastStopFirst: fastStopFirst,
    restoreDone: restoreDone,
    spaceLockout: spaceLockout,
    stopLatch: stopLatch,
    restoreLatch: restoreLatch,
    startLatch: startLatch
  };

  // APB decode; answer comes in the first access cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hitCtrl = paddr == ADDR_CTRL;
  wire hitStatus = paddr == ADDR_STATUS;
  wire hitDegree = paddr == ADDR_DEGREE;
  wire hitRpm = paddr == ADDR_RPM;
  wire hitSkip = paddr == ADDR_SKIP;
  wire mapped = hitCtrl | hitStatus | hitDegree | hitRpm | hitSkip;
  wire writeCtrl = access & pwrite & hitCtrl & ~pslverr;
  wire [31:0] ctrlWord = {{(32-CTRL_W){1'b0}}, ctrl};
  wire [31:0] statusWord = {{(32-$bits(status_s)){1'b0}}, status};
  wire [31:0] degreeWord = {{(32-DEG_W){1'b0}}, degree};
  wire [31:0] rpmWord = {24'h00_0000, rpm};
  wire [31:0] skipWord = {skipEstimate, {(16-LINE_W){1'b0}}, skipLines};
  wire [31:0] readData = hitCtrl ? ctrlWord :
                         hitStatus ? statusWord :
                         hitDegree ? degreeWord :
                         hitRpm ? rpmWord :
                         hitSkip ? skipWord : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl <= CTRL_RESET;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : readData;
      end
      if (writeCtrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
    end
  end

  // Relay latches, one clock per relay step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startLatch <= 1'b0;
      restoreLatch <= 1'b0;
      stopLatch <= 1'b0;
      spaceLockout <= 1'b0;
      restoreDone <= 1'b1;
      camPrev <= '0;
      breakerPrev <= 1'b0;
    end else begin
      startLatch <= next_startLatch;
      restoreLatch <= next_restoreLatch;
      stopLatch <= stopKeyOn;
      spaceLockout <= next_spaceLockout;
      restoreDone <= ~startLatch;
      camPrev <= camClosed;
      breakerPrev <= carriageBreaker;
    end
  end

  // Fast stops respond within one clock of the breaker, far below 1 ms
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fastStopFirst <= 1'b0;
      fastStopSecond <= 1'b0;
      fastStopThird <= 1'b0;
      cancelDelay <= 1'b0;
    end else begin
      fastStopFirst <= next_fastStop;
      fastStopSecond <= next_fastStop;
      fastStopThird <= next_fastStopThird;
      cancelDelay <= next_fastStopThird;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latency <= '0;
      skipLines <= '0;
    end else begin
      if (!startLatch) begin
        latency <= '0;
      end else if (latencyRun) begin
        latency <= latency + LAT_W'(1);
      end
      if (!startLatch) begin
        skipLines <= '0;
      end else if (lineCount) begin
        skipLines <= skipLines + LINE_W'(1);
      end
    end
  end

  // Magnets and host-facing outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motorEnable <= 1'b0;
      clutchMagnet <= 1'b0;
      interposerMagnet <= 1'b0;
      fastClutch <= 1'b0;
      slowClutch <= 1'b0;
    end else begin
      motorEnable <= mainLineOn & gangPunchOff;
      clutchMagnet <= next_clutch;
      interposerMagnet <= next_interposer;
      fastClutch <= next_clutch & fastPath;
      slowClutch <= next_clutch & ~fastPath;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hostRunA <= 1'b0;
      hostRunB <= 1'b0;
      stopPending <= 1'b0;
      hostStop <= 1'b0;
      cancelHold <= '0;
      cancelPending <= 1'b0;
    end else begin
      hostRunA <= next_hostRunA;
      hostRunB <= next_hostRunB;
      stopPending <= next_stopPending;
      hostStop <= stopPending & cycleEnd;
      cancelHold <= next_cancelHold;
      cancelPending <= cancelDelay | holdRun;
    end
  end
endmodule

// ==== csr_chk.sv ====
// Port-level assertions for the carriage space and restore control
`timescale 1ns/1ps
module csr_chk
  import carriage_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mainLineOn,
  input wire logic gangPunchOff,
  input wire keys_s keys,
  input wire logic carriageBreaker,
  input wire logic channel1Brush,
  input wire logic skipSelect,
  input wire logic interposerContact,
  input wire logic motorEnable,
  input wire logic clutchMagnet,
  input wire logic interposerMagnet,
  input wire logic fastClutch,
  input wire logic slowClutch,
  input wire logic hostRunA,
  input wire logic hostRunB,
  input wire logic hostStop,
  input wire logic cancelPending
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_motor_gate: assert property (
    motorEnable |-> $past(mainLineOn && gangPunchOff))
    else $error("motor on without both switches");
  chk_breaker_stop: assert property (
    carriageBreaker && channel1Brush |-> ##2 !clutchMagnet)
    else $error("clutch not dropped after breaker");
  chk_one_path: assert property (
    !(slowClutch && fastClutch) && (clutchMagnet || !(slowClutch || fastClutch)))
    else $error("clutch path inconsistent");
  chk_fast_seal: assert property (
    $rose(fastClutch) |-> $past(interposerMagnet && interposerContact))
    else $error("fast clutch before interposer sealed");
  chk_interposer_cause: assert property (
    $rose(interposerMagnet) |-> $past(skipSelect))
    else $error("interposer without skip select");
  chk_stop_run: assert property (
    keys.stopKey && gangPunchOff |-> ##2 !hostRunA && !hostRunB)
    else $error("run latches kept under stop key");
  chk_stop_clutch: assert property (
    keys.stopKey && gangPunchOff |-> ##[1:4] !clutchMagnet)
    else $error("clutch kept under stop key");
  chk_stop_pulse: assert property (
    hostStop |=> !hostStop)
    else $error("host stop longer than a cycle");
  chk_space_once: assert property (
    $fell(clutchMagnet) && keys == 3'h4 |=> !clutchMagnet [*8])
    else $error("second space while key held");
  chk_restore_hold: assert property (
    $fell(clutchMagnet) && keys.restoreKey |=> !clutchMagnet [*8])
    else $error("clutch back while restore key held");
  chk_cancel_cause: assert property (
    $rose(cancelPending) |-> $past(channel1Brush) || $past(channel1Brush, 2))
    else $error("cancel without channel 1 hole");
  cover property ($rose(fastClutch));
  cover property ($rose(cancelPending));
  cover property (hostStop);
endmodule

bind carriage_space_restore_control csr_chk chk (.clock, .rst_n,
  .mainLineOn, .gangPunchOff, .keys, .carriageBreaker, .channel1Brush,
  .skipSelect, .interposerContact, .motorEnable, .clutchMagnet,
  .interposerMagnet, .fastClutch, .slowClutch, .hostRunA, .hostRunB,
  .hostStop, .cancelPending);

// ==== csr_mech_model.sv ====
// Carriage mechanics: breaker, channel 1 brush, interposer contact
`timescale 1ns/1ps
module csr_mech_model #(
  parameter int LINE_CYC = 20,
  parameter int SEAL_CYC = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clutchMagnet,
  input wire logic interposerMagnet,
  input wire logic [7:0] holeLine,
  output logic carriageBreaker,
  output logic interposerContact,
  output logic [7:0] lineCount,
  output logic channel1Brush
);
  int run;
  int seal;
  // Brush follows tape position, so it stays made at rest on the hole
  assign channel1Brush = lineCount == holeLine;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run <= 0;
      seal <= 0;
      lineCount <= 8'h00;
      carriageBreaker <= 1'h0;
      interposerContact <= 1'h0;
    end else begin
      run <= (clutchMagnet && run <= LINE_CYC) ? run + 1 : 0;
      carriageBreaker <= clutchMagnet && run >= LINE_CYC;
      if (clutchMagnet && run == LINE_CYC) begin
        lineCount <= lineCount + 8'h01;
      end
      seal <= interposerMagnet ? seal + 1 : 0;
      interposerContact <= interposerMagnet && seal >= SEAL_CYC;
    end
  end
endmodule

// ==== carriage_space_restore_control_test.sv ====
// Self-checking bench for the carriage space and restore control
`timescale 1ns/1ps
module carriage_space_restore_control_test
  import carriage_pkg::*;
;
  localparam int DC = 4;
  logic clock, pready, pslverr, e, motorEnable, channel1Brush, hostStop;
  logic rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic mainLineOn = 1'h1, gangPunchOff = 1'h1, skipSelect = 1'h0;
  logic hostStart = 1'h0, carriageBreaker, interposerContact;
  logic clutchMagnet, interposerMagnet, fastClutch, slowClutch;
  logic hostRunA, hostRunB, cancelPending;
  logic [7:0] holeLine = 8'hFF, lineCount;
  keys_s keys = 3'h0;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int cnt;
  carriage_space_restore_control #(.CYC_PER_DEG_100(DC),
    .CYC_PER_DEG_150(3), .CANCEL_HOLD_CYCLES(8)) dut (.clock, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mainLineOn, .gangPunchOff, .keys, .carriageBreaker, .channel1Brush,
    .skipSelect, .interposerContact, .hostStart, .motorEnable,
    .clutchMagnet, .interposerMagnet, .fastClutch, .slowClutch,
    .hostRunA, .hostRunB, .hostStop, .cancelPending);
  csr_mech_model mech (.clock, .rst_n, .clutchMagnet, .interposerMagnet,
    .holeLine, .carriageBreaker, .interposerContact, .lineCount,
    .channel1Brush);
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  function automatic logic pick(int s);
    return s == 0 ? clutchMagnet : s == 1 ? interposerMagnet :
      s == 2 ? cancelPending : s == 3 ? hostStop : fastClutch;
  endfunction
  task automatic await_sig(int s, logic v, int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    check("wait", 32'h1, 32'(n < lim));
  endtask
  task automatic count_clutch(int len);
    cnt = 0;
    repeat (len) begin
      @(posedge clock);
      cnt += int'(clutchMagnet === 1'h1);
    end
  endtask
  task automatic t_regs();
    apb(1'h1, ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("status", 32'h0000_2010, q);
    apb(1'h0, 12'h020, 32'h0);
    check("slverr", 32'h1, 32'(e));
    check("unmapped", 32'h0, q);
    gangPunchOff <= 1'h0;
    keys <= 3'h4;
    count_clutch(80);
    check("punch on", 32'h0, 32'(motorEnable));
    check("key ignored", 32'h0, 32'(cnt));
    keys <= 3'h0;
    gangPunchOff <= 1'h1;
    mainLineOn <= 1'h0;
    repeat (3) @(posedge clock);
    check("line off", 32'h0, 32'(motorEnable));
    mainLineOn <= 1'h1;
    repeat (3) @(posedge clock);
  endtask
  task automatic t_space();
    keys <= 3'h4;
    await_sig(0, 1'h1, 300);
    check("space lat", 32'h1, 32'(n >= 12 * DC && n <= 14 * DC + 4));
    check("slow", 32'h1, 32'(slowClutch));
    apb(1'h0, ADDR_RPM, 32'h0);
    check("slow rpm", 32'h0000_003E, q);
    await_sig(0, 1'h0, 60);
    count_clutch(300);
    check("one space", 32'h0, 32'(cnt));
    keys <= 3'h0;
  endtask
  task automatic t_skip();
    skipSelect <= 1'h1;
    await_sig(1, 1'h1, 1600);
    await_sig(4, 1'h1, 200);
    check("skip lat", 32'h1, 32'(n >= 6 * DC && n <= 8 * DC + 4));
    apb(1'h0, ADDR_RPM, 32'h0);
    check("fast rpm", 32'h0000_0088, q);
    apb(1'h0, ADDR_SKIP, 32'h0);
    check("skip est", 32'h00C8_0000, q);
    await_sig(0, 1'h0, 60);
    skipSelect <= 1'h0;
  endtask
  task automatic t_restore();
    logic prev = 1'h0;
    holeLine <= lineCount + 8'h03;
    keys <= 3'h1;
    await_sig(0, 1'h1, 300);
    cnt = 0;
    while (clutchMagnet !== 1'h0 && cnt < 9) begin
      @(posedge clock);
      cnt += int'(carriageBreaker && !prev);
      prev = carriageBreaker;
    end
    check("lines", 32'h3, 32'(cnt));
    count_clutch(100);
    check("held key", 32'h0, 32'(cnt));
    check("cancel", 32'h1, 32'(cancelPending));
    keys <= 3'h0;
    await_sig(2, 1'h0, 60);
    check("cancel hold", 32'h1, 32'(n >= 8));
    count_clutch(100);
    check("no restart", 32'h0, 32'(cnt));
  endtask
  task automatic t_print();
    int d;
    apb(1'h1, ADDR_CTRL, 32'h3);
    apb(1'h0, ADDR_DEGREE, 32'h0);
    d = 360 - int'(q[8:0]);
    repeat (30) @(posedge clock);
    apb(1'h0, ADDR_DEGREE, 32'h0);
    d = (d + int'(q[8:0])) % 360;
    check("rate150", 32'h1, 32'(d >= 10 && d <= 12));
    await_sig(0, 1'h1, 1200);
    check("cam space", 32'h1, 32'(slowClutch));
    await_sig(0, 1'h0, 60);
    apb(1'h1, ADDR_CTRL, 32'h0);
  endtask
  task automatic t_stop();
    hostStart <= 1'h1;
    @(posedge clock);
    hostStart <= 1'h0;
    // Lockout left by the printed space holds until its cam opens
    do apb(1'h0, ADDR_STATUS, 32'h0);
    while (q[3] !== 1'h0);
    keys <= 3'h4;
    await_sig(0, 1'h1, 300);
    check("run", 32'h3, 32'({hostRunA, hostRunB}));
    keys <= 3'h2;
    repeat (4) @(posedge clock);
    check("stop run", 32'h0, 32'({hostRunA, hostRunB}));
    check("stop clutch", 32'h0, 32'(clutchMagnet));
    await_sig(3, 1'h1, 1600);
    keys <= 3'h0;
    repeat (4) @(posedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    t_regs();
    t_space();
    t_skip();
    t_restore();
    t_print();
    t_stop();
    tally_and_finish();
  end
endmodule
